// *** verilog/afsq_consts.svh ***
// constants for the alarm stop sequencer: object indices, reset values, codes
`ifndef AFSQ_CONSTS_SVH
`define AFSQ_CONSTS_SVH

// object dictionary indices
`define AFSQ_IDX_ALARM_SEQ       16'h3510
`define AFSQ_IDX_FAULT_SEL       16'h605E
`define AFSQ_IDX_PROFILE_DECEL   16'h6084
`define AFSQ_IDX_QSTOP_DECEL     16'h6085
`define AFSQ_IDX_TORQUE_RAMP     16'h6087
`define AFSQ_IDX_HOMING_ACCEL    16'h609A

// reset values of the settings
`define AFSQ_RST_ALARM_SEQ       16'h0000
`define AFSQ_RST_FAULT_SEL       16'h0000
`define AFSQ_RST_RATE            32'h00000000

// selector range accepted as active
`define AFSQ_SEL_MIN             16'sh0000
`define AFSQ_SEL_MAX             16'sh0002

// first-group alarm main codes, sub-codes 0..7
`define AFSQ_GRP_CODE_A          8'h50
`define AFSQ_GRP_CODE_B          8'h51
`define AFSQ_GRP_CODE_C          8'h55
`define AFSQ_GRP_CODE_D          8'h58
`define AFSQ_SUB_MAX             8'h07

// stop threshold in r/min
`define AFSQ_STOP_RPM            16'h001E

// drive state codes reported
`define AFSQ_DSM_OTHER           2'h0
`define AFSQ_DSM_REACT           2'h1
`define AFSQ_DSM_FAULT           2'h2

`endif

// *** verilog/afsq_pkg.sv ***
// types shared by the alarm stop sequencer files
package afsq_pkg;

  // operation mode groups as seen by this block
  typedef enum logic [2:0] {
    AFSQ_MODE_PROFILE_POS,
    AFSQ_MODE_INTERP_POS,
    AFSQ_MODE_PROFILE_VEL,
    AFSQ_MODE_HOMING,
    AFSQ_MODE_TORQUE
  } afsq_mode_t;

  // deceleration source handed to the profile generator
  typedef enum logic [2:0] {
    AFSQ_SRC_NONE,
    AFSQ_SRC_ALARM_SEQ,
    AFSQ_SRC_PROFILE_DECEL,
    AFSQ_SRC_QSTOP_DECEL,
    AFSQ_SRC_HOMING_ACCEL,
    AFSQ_SRC_TORQUE_RAMP
  } afsq_src_t;

  // alarm code: main number and sub number
  typedef struct packed {
    logic [7:0] main;
    logic [7:0] sub;
  } afsq_alarm_t;

  // object write/read request from the fieldbus side
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] index;
    logic [31:0] wdata;
  } afsq_obj_req_t;

  // deceleration command towards the profile generator
  typedef struct packed {
    afsq_src_t   src;
    logic [31:0] rate;
    logic [15:0] alarm_seq;
  } afsq_decel_t;

endpackage

// *** verilog/afsq_src_select.sv ***
// combinational choice of the deceleration source for one alarm
`timescale 1ns/100ps
`default_nettype none
`include "afsq_consts.svh"

module afsq_src_select
  import afsq_pkg::*;
(
  input  wire logic [15:0] fault_sel,   // fault reaction selector
  input  wire afsq_mode_t  mode,        // active operation mode
  input  wire afsq_alarm_t alarm,       // alarm code being raised
  output afsq_src_t        src          // chosen deceleration source
);

  // ------------------------------------------------------------
  // group decode
  // ------------------------------------------------------------
  function automatic logic first_group(input afsq_alarm_t a);
    logic main_hit;
    main_hit = (a.main == `AFSQ_GRP_CODE_A) || (a.main == `AFSQ_GRP_CODE_B) ||
               (a.main == `AFSQ_GRP_CODE_C) || (a.main == `AFSQ_GRP_CODE_D);
    return main_hit && (a.sub <= `AFSQ_SUB_MAX);
  endfunction

  logic sel_ok;

  // out-of-range selector falls back to the alarm sequence
  always_comb begin
    sel_ok = ($signed(fault_sel) >= `AFSQ_SEL_MIN) && ($signed(fault_sel) <= `AFSQ_SEL_MAX);
    src    = AFSQ_SRC_ALARM_SEQ;
    // R08 other alarms
    if (first_group(alarm) && sel_ok) begin
      // R02 first group only
      unique case (mode)
        AFSQ_MODE_PROFILE_POS, AFSQ_MODE_INTERP_POS, AFSQ_MODE_PROFILE_VEL: begin
          // R03 R04 R05 position velocity
          if (fault_sel[1:0] == 2'h1)
            src = AFSQ_SRC_PROFILE_DECEL;
          else if (fault_sel[1:0] == 2'h2)
            src = AFSQ_SRC_QSTOP_DECEL;
        end
        AFSQ_MODE_HOMING: begin
          // R06 homing choices
          if (fault_sel[1:0] == 2'h1)
            src = AFSQ_SRC_HOMING_ACCEL;
          else if (fault_sel[1:0] == 2'h2)
            src = AFSQ_SRC_QSTOP_DECEL;
        end
        AFSQ_MODE_TORQUE: begin
          // R07 torque ramp
          if (fault_sel[1:0] != 2'h0)
            src = AFSQ_SRC_TORQUE_RAMP;
        end
        default: src = AFSQ_SRC_ALARM_SEQ;
      endcase
    end
  end

endmodule
`default_nettype wire

// *** verilog/afsq_sequencer.sv ***
// alarm stop sequencer: settings objects, source choice and fault state
//
// What this block does
// R01 - keeps signed 16-bit fault reaction selector, valid values 0 to 2
// R02 - selector choices apply only to alarm groups 80,81,85,88 sub 0..7
// R03 - position/velocity mode, selector 0: use alarm sequence, then fault
// R04 - position/velocity mode, selector 1: profile deceleration, then fault
// R05 - position/velocity mode, selector 2: quick-stop deceleration, then fault
// R06 - homing: 0 alarm sequence, 1 homing acceleration, 2 quick-stop
// R07 - torque: 0 alarm sequence, 1 or 2 torque ramp, then fault
// R08 - alarms outside first group always use alarm sequence
// R09 - deceleration starts at once on alarm, no master command
// R10 - report fault reaction active while decelerating
// R11 - motor stopped once actual speed at or below stop threshold
// R12 - after stop, drive state moves from reaction active to fault
// R13 - master writes only 0..2; other selector values act as disabled
`timescale 1ns/100ps
`default_nettype none
`include "afsq_consts.svh"

module afsq_sequencer
  import afsq_pkg::*;
#(
  parameter logic [15:0] STOP_RPM = `AFSQ_STOP_RPM  // stop threshold, r/min
)(
  input  wire logic          ref_clk,      // 100 MHz drive clock
  input  wire logic          nrst,         // async reset, active low
  input  wire afsq_obj_req_t obj_req,      // object access from fieldbus master
  output logic [31:0]        obj_rdata,    // read data, registered
  output logic               obj_ack,      // access taken, one cycle
  output logic               obj_err,      // unknown index, one cycle
  input  wire logic          alarm_raise,  // alarm event, one-cycle pulse
  input  wire afsq_alarm_t   alarm_code,   // code valid with alarm_raise
  input  wire afsq_mode_t    op_mode,      // active operation mode
  input  wire logic [15:0]   actual_rpm,   // speed magnitude, r/min
  input  wire logic          fault_clear,  // leave fault state, pulse
  output afsq_decel_t        decel_cmd,    // source and rate, registered
  output logic               decel_run,    // deceleration in progress
  output logic [1:0]         drive_state_machine  // drive state code
);

  // ------------------------------------------------------------
  // settings objects
  // ------------------------------------------------------------
  logic [15:0] alarm_stop_sequence_r,   alarm_stop_sequence_nxt;
  logic [15:0] fault_reaction_select_r, fault_reaction_select_nxt;
  logic [31:0] profile_decel_rate_r,    profile_decel_rate_nxt;
  logic [31:0] quick_stop_decel_rate_r, quick_stop_decel_rate_nxt;
  logic [31:0] torque_ramp_rate_r,      torque_ramp_rate_nxt;
  logic [31:0] homing_accel_rate_r,     homing_accel_rate_nxt;
  logic [31:0] obj_rdata_nxt;
  logic        obj_ack_nxt;
  logic        obj_err_nxt;
  logic        hit;

  // object write and read decode; any value stored, range checked on use
  always_comb begin
    alarm_stop_sequence_nxt   = alarm_stop_sequence_r;
    fault_reaction_select_nxt = fault_reaction_select_r;
    profile_decel_rate_nxt    = profile_decel_rate_r;
    quick_stop_decel_rate_nxt = quick_stop_decel_rate_r;
    torque_ramp_rate_nxt      = torque_ramp_rate_r;
    homing_accel_rate_nxt     = homing_accel_rate_r;
    obj_rdata_nxt             = obj_rdata;
    hit                       = 1'b1;
    unique case (obj_req.index)
      `AFSQ_IDX_ALARM_SEQ: begin
        if (obj_req.wr) alarm_stop_sequence_nxt = obj_req.wdata[15:0];
        if (obj_req.rd) obj_rdata_nxt = {16'h0000, alarm_stop_sequence_r};
      end
      `AFSQ_IDX_FAULT_SEL: begin
        // R01 signed selector store
        if (obj_req.wr) fault_reaction_select_nxt = obj_req.wdata[15:0];
        if (obj_req.rd) obj_rdata_nxt = {{16{fault_reaction_select_r[15]}}, fault_reaction_select_r};
      end
      `AFSQ_IDX_PROFILE_DECEL: begin
        if (obj_req.wr) profile_decel_rate_nxt = obj_req.wdata;
        if (obj_req.rd) obj_rdata_nxt = profile_decel_rate_r;
      end
      `AFSQ_IDX_QSTOP_DECEL: begin
        if (obj_req.wr) quick_stop_decel_rate_nxt = obj_req.wdata;
        if (obj_req.rd) obj_rdata_nxt = quick_stop_decel_rate_r;
      end
      `AFSQ_IDX_TORQUE_RAMP: begin
        if (obj_req.wr) torque_ramp_rate_nxt = obj_req.wdata;
        if (obj_req.rd) obj_rdata_nxt = torque_ramp_rate_r;
      end
      `AFSQ_IDX_HOMING_ACCEL: begin
        if (obj_req.wr) homing_accel_rate_nxt = obj_req.wdata;
        if (obj_req.rd) obj_rdata_nxt = homing_accel_rate_r;
      end
      default: begin
        hit = 1'b0;
        if (obj_req.rd) obj_rdata_nxt = 32'h00000000;
      end
    endcase
    obj_ack_nxt = obj_req.wr | obj_req.rd;
    obj_err_nxt = (obj_req.wr | obj_req.rd) & ~hit;
  end

  // settings registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      alarm_stop_sequence_r   <= `AFSQ_RST_ALARM_SEQ;
      fault_reaction_select_r <= `AFSQ_RST_FAULT_SEL;
      profile_decel_rate_r    <= `AFSQ_RST_RATE;
      quick_stop_decel_rate_r <= `AFSQ_RST_RATE;
      torque_ramp_rate_r      <= `AFSQ_RST_RATE;
      homing_accel_rate_r     <= `AFSQ_RST_RATE;
      obj_rdata               <= 32'h00000000;
      obj_ack                 <= 1'b0;
      obj_err                 <= 1'b0;
    end else begin
      alarm_stop_sequence_r   <= alarm_stop_sequence_nxt;
      fault_reaction_select_r <= fault_reaction_select_nxt;
      profile_decel_rate_r    <= profile_decel_rate_nxt;
      quick_stop_decel_rate_r <= quick_stop_decel_rate_nxt;
      torque_ramp_rate_r      <= torque_ramp_rate_nxt;
      homing_accel_rate_r     <= homing_accel_rate_nxt;
      obj_rdata               <= obj_rdata_nxt;
      obj_ack                 <= obj_ack_nxt;
      obj_err                 <= obj_err_nxt;
    end
  end

  // ------------------------------------------------------------
  // source choice
  // ------------------------------------------------------------
  afsq_src_t chosen_src;

  // R13 out-of-range selector disabled
  afsq_src_select u_src_select (
    .fault_sel (fault_reaction_select_r),
    .mode      (op_mode),
    .alarm     (alarm_code),
    .src       (chosen_src)
  );

  // rate of the chosen source; alarm sequence carries its own setting
  function automatic logic [31:0] rate_of(input afsq_src_t s);
    unique case (s)
      AFSQ_SRC_PROFILE_DECEL: return profile_decel_rate_r;
      AFSQ_SRC_QSTOP_DECEL:   return quick_stop_decel_rate_r;
      AFSQ_SRC_HOMING_ACCEL:  return homing_accel_rate_r;
      AFSQ_SRC_TORQUE_RAMP:   return torque_ramp_rate_r;
      default:                return 32'h00000000;
    endcase
  endfunction

  // ------------------------------------------------------------
  // drive state sequence
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN,
    ST_REACT,
    ST_FAULT
  } afsq_state_t;

  afsq_state_t state_r, state_nxt;
  afsq_decel_t decel_r, decel_nxt;
  logic        stopped;
  logic [1:0]  dsm_r, dsm_nxt;

  // speed compare is not filtered; measurement noise is the caller's to handle
  always_comb begin
    // R11 stop threshold
    stopped   = (actual_rpm <= STOP_RPM);
    state_nxt = state_r;
    decel_nxt = decel_r;
    unique case (state_r)
      ST_RUN: begin
        if (alarm_raise) begin
          // R09 start at once
          state_nxt           = ST_REACT;
          decel_nxt.src       = chosen_src;
          decel_nxt.rate      = rate_of(chosen_src);
          decel_nxt.alarm_seq = alarm_stop_sequence_r;
        end
      end
      ST_REACT: begin
        // R12 stop leads to fault
        if (stopped) begin
          state_nxt     = ST_FAULT;
          decel_nxt.src = AFSQ_SRC_NONE;
        end
      end
      ST_FAULT: begin
        // later alarms while in fault do not restart the reaction
        if (fault_clear) begin
          state_nxt = ST_RUN;
          decel_nxt = '{AFSQ_SRC_NONE, 32'h00000000, 16'h0000};
        end
      end
      default: begin
        // unused state code: fall back to run with a cleared command
        state_nxt = ST_RUN;
        decel_nxt = '{AFSQ_SRC_NONE, 32'h00000000, 16'h0000};
      end
    endcase
    // registered state code keeps the pins free of decode glitches
    dsm_nxt = (state_nxt == ST_REACT) ? `AFSQ_DSM_REACT :
              (state_nxt == ST_FAULT) ? `AFSQ_DSM_FAULT : `AFSQ_DSM_OTHER;
  end

  // state and command registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_RUN;
      decel_r <= '{AFSQ_SRC_NONE, 32'h00000000, 16'h0000};
      dsm_r   <= `AFSQ_DSM_OTHER;
    end else begin
      state_r <= state_nxt;
      decel_r <= decel_nxt;
      dsm_r   <= dsm_nxt;
    end
  end

  // R10 report reaction active
  assign decel_run           = (state_r == ST_REACT);
  assign decel_cmd           = decel_r;
  assign drive_state_machine = dsm_r;

endmodule
`default_nettype wire

// *** test/afsq_seq_asserts.sv ***
// port checker for the alarm stop sequencer
`timescale 1ns/100ps
`default_nettype none
module afsq_seq_asserts
  import afsq_pkg::*;
#(
  parameter logic [15:0] STOP_RPM = 16'h001E  // stop threshold
)(
  input wire logic          ref_clk,              // clock
  input wire logic          nrst,                 // reset, low
  input wire afsq_obj_req_t obj_req,              // object access
  input wire logic [31:0]   obj_rdata,            // read data
  input wire logic          obj_ack,              // ack pulse
  input wire logic          obj_err,              // error pulse
  input wire logic          alarm_raise,          // alarm event
  input wire afsq_alarm_t   alarm_code,           // alarm code
  input wire afsq_mode_t    op_mode,              // mode
  input wire logic [15:0]   actual_rpm,           // speed
  input wire logic          fault_clear,          // fault exit
  input wire afsq_decel_t   decel_cmd,            // decel command
  input wire logic          decel_run,            // decelerating
  input wire logic [1:0]    drive_state_machine   // state code
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // first alarm group: four main codes, sub 0..7
  wire logic grp1_hit = (alarm_code.main inside {8'h50, 8'h51, 8'h55, 8'h58}) && alarm_code.sub <= 8'h07;
  wire logic idle_alarm = alarm_raise && drive_state_machine == 2'h0;
  a_ack_follow: assert property ((obj_req.wr || obj_req.rd) |=> obj_ack)
    else $error("object access not acknowledged");
  a_err_ack: assert property (obj_err |-> obj_ack)
    else $error("error without ack");
  a_alarm_start: assert property (idle_alarm |=> drive_state_machine == 2'h1 && decel_run)
    else $error("alarm did not start reaction");
  a_react_flag: assert property (decel_run == (drive_state_machine == 2'h1))
    else $error("run flag differs from state");
  a_react_hold: assert property (drive_state_machine == 2'h1 && actual_rpm > STOP_RPM |=> drive_state_machine == 2'h1)
    else $error("reaction left while fast");
  a_src_kept: assert property (drive_state_machine == 2'h1 ##1 drive_state_machine == 2'h1 |-> $stable(decel_cmd))
    else $error("decel command changed in reaction");
  a_stop_fault: assert property (drive_state_machine == 2'h1 && actual_rpm <= STOP_RPM |=> drive_state_machine == 2'h2 && decel_cmd.src == AFSQ_SRC_NONE)
    else $error("no fault after stop");
  a_fault_hold: assert property (drive_state_machine == 2'h2 && !fault_clear |=> drive_state_machine == 2'h2)
    else $error("fault state left");
  a_other_group: assert property (idle_alarm && !grp1_hit |=> decel_cmd.src == AFSQ_SRC_ALARM_SEQ)
    else $error("other group not on alarm sequence");
  c_reach_fault: cover property (drive_state_machine == 2'h1 ##1 drive_state_machine == 2'h2);
  c_obj_err: cover property (obj_err);
  c_alarm_in_fault: cover property (alarm_raise && drive_state_machine == 2'h2);
endmodule
bind afsq_sequencer afsq_seq_asserts #(.STOP_RPM(STOP_RPM)) chk (
  .ref_clk(ref_clk), .nrst(nrst), .obj_req(obj_req), .obj_rdata(obj_rdata), .obj_ack(obj_ack),
  .obj_err(obj_err), .alarm_raise(alarm_raise), .alarm_code(alarm_code), .op_mode(op_mode),
  .actual_rpm(actual_rpm), .fault_clear(fault_clear), .decel_cmd(decel_cmd), .decel_run(decel_run),
  .drive_state_machine(drive_state_machine));
`default_nettype wire

// *** test/afsq_master_model.sv ***
// fieldbus master model issuing object reads and writes
`timescale 1ns/100ps
`default_nettype none
module afsq_master_model
  import afsq_pkg::*;
(
  input  wire logic        ref_clk,    // drive clock
  output var afsq_obj_req_t obj_req,   // request to device
  input  wire logic [31:0] obj_rdata,  // read data
  input  wire logic        obj_ack,    // access taken
  input  wire logic        obj_err     // unknown index
);
  initial obj_req = '0;
  // one-cycle pulse; answer is taken one edge after the request edge
  task automatic access(input logic wr, input logic [15:0] ix, input logic [31:0] wd,
                        output logic ack, output logic err, output logic [31:0] rd);
    @(posedge ref_clk);
    #1 obj_req = '{wr: wr, rd: !wr, index: ix, wdata: wd};
    @(posedge ref_clk);
    // released lines carry inverted leftovers so stale values never pass
    #1 obj_req = '{wr: 1'b0, rd: 1'b0, index: ~ix, wdata: ~wd};
    ack = obj_ack;
    err = obj_err;
    rd = obj_rdata;
  endtask
endmodule
`default_nettype wire

// *** test/test_afsq_sequencer.sv ***
// self-checking testbench for the alarm stop sequencer
`timescale 1ns/100ps
`default_nettype none
module test_afsq_sequencer import afsq_pkg::*;;
  logic          ref_clk = 1'b0, nrst = 1'b0, alarm_raise = 1'b0, fault_clear = 1'b0;
  logic          obj_ack, obj_err, decel_run;
  logic [31:0]   obj_rdata;
  logic [1:0]    drive_state_machine;
  logic [15:0]   actual_rpm = 16'h0100;
  afsq_obj_req_t obj_req;
  afsq_alarm_t   alarm_code = '0;
  afsq_mode_t    op_mode = AFSQ_MODE_PROFILE_POS;
  afsq_decel_t   decel_cmd;
  int            fails = 0, checks_done = 0, cyc = 0;
  logic [15:0]   idx [6] = '{16'h3510, 16'h605E, 16'h6084, 16'h6085, 16'h6087, 16'h609A};
  logic [31:0]   wv [6] = '{32'hFFFF0005, 32'h00000002, 32'hA1B2C3D4, 32'h00001111, 32'h00002222, 32'h00003333};
  logic [31:0]   rb [6] = '{32'h00000005, 32'h00000002, 32'hA1B2C3D4, 32'h00001111, 32'h00002222, 32'h00003333};
  logic [7:0]    gm [4] = '{8'h50, 8'h51, 8'h55, 8'h58};
  afsq_src_t     es;

  always #5 ref_clk = ~ref_clk;

  afsq_sequencer uut (
    .ref_clk(ref_clk), .nrst(nrst), .obj_req(obj_req), .obj_rdata(obj_rdata), .obj_ack(obj_ack),
    .obj_err(obj_err), .alarm_raise(alarm_raise), .alarm_code(alarm_code), .op_mode(op_mode),
    .actual_rpm(actual_rpm), .fault_clear(fault_clear), .decel_cmd(decel_cmd), .decel_run(decel_run),
    .drive_state_machine(drive_state_machine));
  afsq_master_model mstr (
    .ref_clk(ref_clk), .obj_req(obj_req), .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err));

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // whole run needs well under a thousand cycles; this cuts a hang
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails = fails + 1;
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic obj(input logic wr, input logic [15:0] ix, input logic [31:0] wd,
                     input logic [31:0] er, input logic ee);
    logic a, e;
    logic [31:0] r;
    mstr.access(wr, ix, wd, a, e, r);
    check(a, 1'b1);
    check(e, ee);
    if (!wr) check(r, er);
  endtask

  // ----------------------------------------
  // expected source and rate
  // ----------------------------------------
  function automatic afsq_src_t exp_src(afsq_mode_t m, int s, bit g);
    if (!g || s == 0) return AFSQ_SRC_ALARM_SEQ;
    if (m == AFSQ_MODE_TORQUE) return AFSQ_SRC_TORQUE_RAMP;
    if (s == 2) return AFSQ_SRC_QSTOP_DECEL;
    return (m == AFSQ_MODE_HOMING) ? AFSQ_SRC_HOMING_ACCEL : AFSQ_SRC_PROFILE_DECEL;
  endfunction

  function automatic logic [31:0] rate_of(afsq_src_t s);
    case (s)
      AFSQ_SRC_PROFILE_DECEL: return wv[2];
      AFSQ_SRC_QSTOP_DECEL:   return wv[3];
      AFSQ_SRC_TORQUE_RAMP:   return wv[4];
      AFSQ_SRC_HOMING_ACCEL:  return wv[5];
      default:                return 32'h0;
    endcase
  endfunction

  // alarm, refused alarms in reaction and in fault, stop at the threshold, clear
  task automatic run_alarm(input afsq_mode_t m, input afsq_alarm_t c, input afsq_src_t e);
    @(posedge ref_clk);
    #1 op_mode = m;
    alarm_code = c;
    alarm_raise = 1'b1;
    actual_rpm = 16'h001F;
    @(posedge ref_clk);
    #1 check(drive_state_machine, 2'h1);
    check(decel_run, 1'b1);
    check(decel_cmd.src, e);
    check(decel_cmd.rate, rate_of(e));
    check(decel_cmd.alarm_seq, 16'h0005);
    alarm_code = '{8'h01, 8'h00};
    @(posedge ref_clk);
    #1 check(drive_state_machine, 2'h1);
    check(decel_cmd.src, e);
    actual_rpm = 16'h001E;
    @(posedge ref_clk);
    #1 check(drive_state_machine, 2'h2);
    check(decel_cmd.src, AFSQ_SRC_NONE);
    @(posedge ref_clk);
    #1 check(drive_state_machine, 2'h2);
    alarm_raise = 1'b0;
    fault_clear = 1'b1;
    @(posedge ref_clk);
    #1 fault_clear = 1'b0;
    check(drive_state_machine, 2'h0);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    #1 nrst = 1'b1;
    foreach (idx[i]) obj(1'b0, idx[i], 32'h0, 32'h0, 1'b0);
    foreach (idx[i]) obj(1'b1, idx[i], wv[i], 32'h0, 1'b0);
    foreach (idx[i]) obj(1'b0, idx[i], 32'h0, rb[i], 1'b0);
    obj(1'b1, 16'h6086, 32'h5A5A5A5A, 32'h0, 1'b1);
    obj(1'b0, 16'h6086, 32'h0, 32'h0, 1'b1);
    $display("test registers done");
    for (int s = 0; s < 3; s++) begin
      obj(1'b1, 16'h605E, 32'(s), 32'h0, 1'b0);
      for (int m = 0; m < 5; m++) begin
        // sub 7 in group; sub 8 or main 4F outside
        for (int g = 0; g < 3; g++) begin
          es = exp_src(afsq_mode_t'(m), s, g == 1);
          run_alarm(afsq_mode_t'(m), '{(g == 2) ? 8'h4F : gm[m % 4], (g == 0) ? 8'h08 : 8'h07}, es);
        end
      end
    end
    $display("test alarm matrix done");
    // out-of-range selector acts as disabled, reads back sign-extended
    obj(1'b1, 16'h605E, 32'h0000FFFE, 32'h0, 1'b0);
    obj(1'b0, 16'h605E, 32'h0, 32'hFFFFFFFE, 1'b0);
    run_alarm(AFSQ_MODE_PROFILE_VEL, '{8'h50, 8'h00}, AFSQ_SRC_ALARM_SEQ);
    obj(1'b1, 16'h605E, 32'h00000005, 32'h0, 1'b0);
    run_alarm(AFSQ_MODE_HOMING, '{8'h58, 8'h07}, AFSQ_SRC_ALARM_SEQ);
    $display("test selector range done");
    // reset in mid reaction drops the reaction and the settings
    @(posedge ref_clk);
    #1 alarm_raise = 1'b1;
    @(posedge ref_clk);
    #1 alarm_raise = 1'b0;
    nrst = 1'b0;
    @(posedge ref_clk);
    #1 check(drive_state_machine, 2'h0);
    check(decel_run, 1'b0);
    check(decel_cmd.src, AFSQ_SRC_NONE);
    nrst = 1'b1;
    obj(1'b0, 16'h605E, 32'h0, 32'h0, 1'b0);
    obj(1'b0, 16'h6084, 32'h0, 32'h0, 1'b0);
    $display("test mid-run reset done");
    final_report();
  end
endmodule
`default_nettype wire
